// >>> hdl/cnl_pkg.sv
package cnl_pkg;

	// ***************************************************************
	// clock and pattern timing
	// ***************************************************************
	localparam int unsigned CLK_FREQ_KHZ  = 250_000;
	localparam int unsigned LED_TICK_MS   = 50;
	localparam int unsigned FLASH_ON_MS   = 200;
	localparam int unsigned FLASH_LONG_MS = 1000;
	// ms times kHz gives cycles; 50 ms at 250 MHz is 12.5 million cycles
	localparam int unsigned LED_TICK_CYC  = LED_TICK_MS * CLK_FREQ_KHZ;
	localparam logic [6:0]  ON_TICKS      = 7'(FLASH_ON_MS / LED_TICK_MS);
	localparam logic [6:0]  LONG_TICKS    = 7'(FLASH_LONG_MS / LED_TICK_MS);

	// ***************************************************************
	// setting switches and stored configuration
	// ***************************************************************
	localparam logic [3:0] SW_DIGIT_MAX = 4'h9;
	localparam logic [3:0] SW_ZERO      = 4'h0;
	localparam logic [6:0] ID_TENS_MUL  = 7'h0a;
	localparam logic [6:0] CFG_ID_RST   = 7'h01;
	localparam logic [3:0] CFG_RATE_RST = 4'h5;

	// ***************************************************************
	// register map, byte addresses and field positions
	// ***************************************************************
	localparam logic [7:0] REG_CFG_OFS  = 8'h00;
	localparam logic [7:0] REG_EVT_OFS  = 8'h04;
	localparam logic [7:0] REG_SET_OFS  = 8'h08;
	localparam logic [7:0] REG_LED_OFS  = 8'h0c;
	localparam int unsigned F_ID_LSB    = 0;
	localparam int unsigned F_RATE_LSB  = 8;
	localparam int unsigned F_ID_SRC    = 12;
	localparam int unsigned F_RATE_SRC  = 13;
	localparam int unsigned F_DONE      = 14;
	localparam int unsigned F_ERRM_LSB  = 0;
	localparam int unsigned F_RUNM_LSB  = 4;
	localparam int unsigned F_ERR_LED   = 8;
	localparam int unsigned F_RUN_LED   = 9;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	// ***************************************************************
	// network management states as reported by the protocol stack
	// ***************************************************************
	localparam logic [1:0] NMT_INIT  = 2'h0;
	localparam logic [1:0] NMT_PREOP = 2'h1;
	localparam logic [1:0] NMT_OPER  = 2'h2;
	localparam logic [1:0] NMT_STOP  = 2'h3;

	typedef enum logic [2:0] {
		LM_OFF   = 3'b000,
		LM_ON    = 3'b001,
		LM_FLICK = 3'b010,
		LM_BLINK = 3'b011,
		LM_FL1   = 3'b100,
		LM_FL2   = 3'b101,
		LM_FL3   = 3'b110,
		LM_FL4   = 3'b111
	} cnl_led_mode_t;

	typedef enum logic {
		SMP_WAIT = 1'b0,
		SMP_DONE = 1'b1
	} cnl_smp_state_t;

	// bit rate in kbit/s for a rate code; zero for an unused code
	function automatic logic [10:0] cnl_rate_kbps(input logic [3:0] code);
		logic [10:0] r;
		r = 11'h000;
		unique case (code)
			4'h1: r = 11'd10;
			4'h2: r = 11'd20;
			4'h3: r = 11'd50;
			4'h4: r = 11'd100;
			4'h5: r = 11'd125;
			4'h6: r = 11'd250;
			4'h7: r = 11'd500;
			4'h8: r = 11'd800;
			4'h9: r = 11'd1000;
			default: r = 11'h000;
		endcase
		return r;
	endfunction

endpackage

// >>> hdl/cnl_top.sv
// Notes on behaviour
// - left switch codes 1-9 select bit rate
// - rate switch zero uses stored rate, default 125k
// - two right switches give node id 1-99
// - id switches zero use stored id, default 1
// - stored id may reach 127
// - error LED dark without any error
// - setting services: both LEDs flicker, opposite phase
// - warning limit gives error LED single flash
// - guard or heartbeat event gives double flash
// - sync timeout gives error LED triple flash
// - bus off lights error LED steadily
// - pre-operational state blinks run LED
// - stopped state single-flashes run LED
// - operational state lights run LED steadily
// - flicker is 50 ms on, 50 ms off
// - blink is 200 ms on, 200 ms off
// - single flash: 200 ms on, 1000 ms off
// - multi flash: 200 ms flashes, gaps, long off
`timescale 1ns/10ps
`default_nettype none

module cnl_top
	import cnl_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = LED_TICK_CYC
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// setting switches
	input  wire logic [3:0]  sw_rate_i,
	input  wire logic [3:0]  sw_id_tens_i,
	input  wire logic [3:0]  sw_id_units_i,
	// protocol and controller status
	input  wire logic        lss_busy_i,
	input  wire logic        warn_limit_i,
	input  wire logic        bus_off_i,
	input  wire logic        guard_evt_i,
	input  wire logic        hb_evt_i,
	input  wire logic        sync_err_i,
	input  wire logic [1:0]  nmt_state_i,
	// decoded settings and indicators
	output logic [6:0]       node_id_o,
	output logic [10:0]      rate_kbps_o,
	output logic             setting_done_o,
	output logic             err_led_o,
	output logic             run_led_o,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ***************************************************************
	// register bus slave
	// ***************************************************************
	logic           awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]     bresp_q, rresp_q;
	logic [31:0]    rdata_q, wdata_q;
	logic [7:0]     awaddr_q;
	logic [3:0]     wstrb_q;
	logic [6:0]     cfg_id_q   = CFG_ID_RST;
	logic [3:0]     cfg_rate_q = CFG_RATE_RST;
	logic           evt_flag_q;
	logic [6:0]     node_id_q;
	logic [3:0]     rate_code_q;
	logic           id_src_q, rate_src_q;
	cnl_smp_state_t smp_q;
	cnl_led_mode_t  mode_d [2];
	cnl_led_mode_t  mode_q [2];
	logic           led_q  [2];

	wire aw_take = s_axi_awvalid && awready_q;
	wire w_take  = s_axi_wvalid && wready_q;
	wire ar_take = s_axi_arvalid && arready_q;
	// both halves held and no response pending: the write acts now
	wire wr_go   = !awready_q && !wready_q && !bvalid_q;
	wire b_done  = bvalid_q && s_axi_bready;
	wire r_done  = rvalid_q && s_axi_rready;

	wire wr_cfg  = wr_go && (awaddr_q == REG_CFG_OFS);
	wire wr_evt  = wr_go && (awaddr_q == REG_EVT_OFS);
	wire wr_hit  = wr_cfg || wr_evt;

	wire [31:0] rd_cfg = 32'({cfg_rate_q, 1'b0, cfg_id_q} << F_ID_LSB);
	wire [31:0] rd_evt = {31'h0000_0000, evt_flag_q};
	wire [31:0] rd_set = 32'({smp_q == SMP_DONE, rate_src_q, id_src_q, rate_code_q,
	                          1'b0, node_id_q} << F_ID_LSB);
	wire [31:0] rd_led = 32'({led_q[1], led_q[0], 1'b0, mode_q[1], 1'b0, mode_q[0]}
	                         << F_ERRM_LSB);
	wire        rd_hit = (s_axi_araddr == REG_CFG_OFS) || (s_axi_araddr == REG_EVT_OFS)
	                  || (s_axi_araddr == REG_SET_OFS) || (s_axi_araddr == REG_LED_OFS);
	wire [31:0] rd_mux = (s_axi_araddr == REG_CFG_OFS) ? rd_cfg :
	                     (s_axi_araddr == REG_EVT_OFS) ? rd_evt :
	                     (s_axi_araddr == REG_SET_OFS) ? rd_set :
	                     (s_axi_araddr == REG_LED_OFS) ? rd_led : 32'h0000_0000;

	// write channels: each half is taken alone, released after the response
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (aw_take) begin
				awready_q <= 1'b0;
				awaddr_q  <= s_axi_awaddr;
			end
			if (w_take) begin
				wready_q <= 1'b0;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (b_done) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// read channel: data registered at the address handshake
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end else if (ar_take) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_mux;
			rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (r_done) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	// ***************************************************************
	// stored configuration and error-control event flag
	// ***************************************************************
	wire evt_set = guard_evt_i || hb_evt_i;
	wire evt_clr = wr_evt && wstrb_q[0] && wdata_q[0];

	// stored values stand for the non-volatile copy, so rst_i leaves them
	// alone: a value written here reaches the decode at the next reset;
	// the declarations give the factory defaults, all 7 id bits are kept
	always_ff @(posedge sys_clk_i) begin
		if (wr_cfg) begin
			if (wstrb_q[0]) cfg_id_q   <= wdata_q[F_ID_LSB +: 7];
			if (wstrb_q[1]) cfg_rate_q <= wdata_q[F_RATE_LSB +: 4];
		end
	end

	// sticky event, write one to clear; a new event beats the clear
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) evt_flag_q <= 1'b0;
		else       evt_flag_q <= evt_set || (evt_flag_q && !evt_clr);
	end

	// ***************************************************************
	// setting switch decode, taken once after reset
	// ***************************************************************
	wire       tens_ok  = sw_id_tens_i <= SW_DIGIT_MAX;
	wire       units_ok = sw_id_units_i <= SW_DIGIT_MAX;
	wire [6:0] sw_id    = 7'(sw_id_tens_i * ID_TENS_MUL) + {3'b000, sw_id_units_i};
	// an out-of-range digit is treated like all-zero switches, so a bad switch
	// takes the stored id, which may reach 127
	wire       id_store   = !tens_ok || !units_ok || (sw_id == 7'h00);
	wire       rate_store = (sw_rate_i == SW_ZERO) || (sw_rate_i > SW_DIGIT_MAX);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			smp_q       <= SMP_WAIT;
			node_id_q   <= 7'h00;
			rate_code_q <= 4'h0;
			id_src_q    <= 1'b0;
			rate_src_q  <= 1'b0;
		end else if (smp_q == SMP_WAIT) begin
			smp_q       <= SMP_DONE;
			node_id_q   <= id_store ? cfg_id_q : sw_id;
			rate_code_q <= rate_store ? cfg_rate_q : sw_rate_i;
			id_src_q    <= id_store;
			rate_src_q  <= rate_store;
		end
	end

	// ***************************************************************
	// pattern time base
	// ***************************************************************
	logic [23:0] tick_cnt_q;
	logic        tick_q, flick_q;
	wire         tick_wrap = tick_cnt_q == 24'(TICK_CYCLES - 1);

	// one tick per 50 ms; flicker phase toggles on every tick
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt_q <= 24'h00_0000;
			tick_q     <= 1'b0;
			flick_q    <= 1'b0;
		end else begin
			tick_cnt_q <= tick_wrap ? 24'h00_0000 : tick_cnt_q + 24'h00_0001;
			tick_q     <= tick_wrap;
			if (tick_q) flick_q <= !flick_q;
		end
	end

	// ***************************************************************
	// indicator mode selection
	// ***************************************************************
	// error LED, most severe first; setting services override all
	assign mode_d[0] = lss_busy_i  ? LM_FLICK :
	                   bus_off_i   ? LM_ON    :
	                   sync_err_i  ? LM_FL3   :
	                   evt_flag_q  ? LM_FL2   :
	                   warn_limit_i ? LM_FL1  :
	                   LM_OFF;
	// run LED from the network-management state
	assign mode_d[1] = lss_busy_i                ? LM_FLICK :
	                   (nmt_state_i == NMT_PREOP) ? LM_BLINK :
	                   (nmt_state_i == NMT_STOP)  ? LM_FL1   :
	                   (nmt_state_i == NMT_OPER)  ? LM_ON    :
	                   LM_OFF;

	// ***************************************************************
	// pattern generator, one per LED
	// ***************************************************************
	logic [6:0] step_q [2];
	for (genvar g = 0; g < 2; g++) begin : g_led
		wire       flash    = mode_q[g][2];
		// flash count n gives 2n-1 lit-or-gap slots before the long off
		wire [6:0] lit_len  = 7'({mode_q[g][1:0], 1'b1} * ON_TICKS);
		wire [6:0] frame    = flash ? lit_len + LONG_TICKS : ON_TICKS + ON_TICKS;
		wire [6:0] slot     = step_q[g] / ON_TICKS;
		wire       step_end = step_q[g] == frame - 7'h01;
		wire       flash_on = (step_q[g] < lit_len) && !slot[0];
		wire       ph       = (g == 0) ? flick_q : !flick_q;
		wire       led_d    = (mode_q[g] == LM_ON)    ? 1'b1 :
		                      (mode_q[g] == LM_FLICK) ? ph :
		                      (mode_q[g] == LM_BLINK) ? !slot[0] :
		                      flash ? flash_on : 1'b0;

		// a mode change restarts a blink or flash pattern at its first lit phase
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				mode_q[g] <= LM_OFF;
				step_q[g] <= 7'h00;
				led_q[g]  <= 1'b0;
			end else begin
				mode_q[g] <= mode_d[g];
				led_q[g]  <= led_d;
				if (mode_q[g] != mode_d[g])      step_q[g] <= 7'h00;
				else if (tick_q && step_end)     step_q[g] <= 7'h00;
				else if (tick_q)                 step_q[g] <= step_q[g] + 7'h01;
			end
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign s_axi_awready  = awready_q;
	assign s_axi_wready   = wready_q;
	assign s_axi_bvalid   = bvalid_q;
	assign s_axi_bresp    = bresp_q;
	assign s_axi_arready  = arready_q;
	assign s_axi_rvalid   = rvalid_q;
	assign s_axi_rdata    = rdata_q;
	assign s_axi_rresp    = rresp_q;
	assign err_led_o      = led_q[0];
	assign run_led_o      = led_q[1];
	assign node_id_o      = node_id_q;
	assign setting_done_o = smp_q == SMP_DONE;

	logic [10:0] rate_kbps_q;
	// registered so the output pin comes straight from a flip-flop
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) rate_kbps_q <= 11'h000;
		else       rate_kbps_q <= cnl_rate_kbps(rate_code_q);
	end
	assign rate_kbps_o = rate_kbps_q;

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// antecedents on pins skip the edge that releases reset: the design is
	// still held there, so its capture only shows one edge later

	a_settings_held: assert property (smp_q == SMP_DONE && $past(smp_q == SMP_DONE)
		|-> $stable(node_id_q) && $stable(rate_code_q))
		else $error("settings changed after sampling");
	a_id_from_sw: assert property (!rst_i && smp_q == SMP_WAIT && tens_ok && units_ok
		&& sw_id != 7'h00 |=> node_id_q == $past(sw_id) && !id_src_q)
		else $error("node id not taken from switches");
	a_id_from_store: assert property (smp_q == SMP_WAIT && sw_id_tens_i == SW_ZERO
		&& sw_id_units_i == SW_ZERO && !rst_i |=> node_id_q == $past(cfg_id_q) && id_src_q)
		else $error("node id not taken from store");
	a_rate_table: assert property (smp_q == SMP_DONE && $past(smp_q == SMP_DONE)
		|-> rate_kbps_o == cnl_rate_kbps(rate_code_q))
		else $error("bit rate output mismatch");
	a_rate_store: assert property (!rst_i && smp_q == SMP_WAIT && sw_rate_i == SW_ZERO
		|=> rate_code_q == $past(cfg_rate_q) ##1 rate_kbps_o != 11'h000)
		else $error("bit rate not taken from store");
	a_err_dark: assert property (mode_q[0] == LM_OFF ##1 mode_q[0] == LM_OFF
		|-> !err_led_o)
		else $error("error LED lit without error");
	a_lss_alt: assert property (mode_q[0] == LM_FLICK && mode_q[1] == LM_FLICK
		|=> err_led_o != run_led_o)
		else $error("flicker not in opposite phase");
	a_err_prio: assert property (!rst_i && !lss_busy_i && bus_off_i
		|=> mode_q[0] == LM_ON ##1 err_led_o)
		else $error("bus off not shown steadily");
	a_sync_prio: assert property (!rst_i && !lss_busy_i && !bus_off_i && sync_err_i
		|=> mode_q[0] == LM_FL3)
		else $error("sync error not shown as triple flash");
	a_evt_flash: assert property (!rst_i && !lss_busy_i && !bus_off_i && !sync_err_i
		&& (guard_evt_i || hb_evt_i) ##1 !lss_busy_i && !bus_off_i && !sync_err_i
		|=> mode_q[0] == LM_FL2)
		else $error("error-control event not shown");
	a_warn_flash: assert property (!rst_i && !lss_busy_i && !bus_off_i && !sync_err_i
		&& !evt_flag_q && warn_limit_i |=> mode_q[0] == LM_FL1)
		else $error("warning limit not shown");
	a_run_states: assert property (!rst_i && !lss_busy_i |=> mode_q[1] ==
		($past(nmt_state_i) == NMT_PREOP ? LM_BLINK : $past(nmt_state_i) == NMT_STOP
		? LM_FL1 : $past(nmt_state_i) == NMT_OPER ? LM_ON : LM_OFF))
		else $error("run LED mode wrong for state");
	a_flick_rate: assert property ($changed(flick_q) |-> $past(tick_cnt_q) == 24'h00_0000
		&& $past(tick_q))
		else $error("flicker toggled off the tick");
	a_flash_frame: assert property (mode_q[0] == LM_FL1 && $stable(mode_q[0])
		|-> step_q[0] < ON_TICKS + LONG_TICKS)
		else $error("single flash frame too long");
	a_cfg_write: assert property (wr_cfg && wstrb_q[0]
		|=> cfg_id_q == $past(wdata_q[F_ID_LSB +: 7]))
		else $error("stored node id not written");
	a_evt_set_wins: assert property (evt_set |=> evt_flag_q)
		else $error("error-control event lost");

	c_lss: cover property (lss_busy_i ##1 mode_q[0] == LM_FLICK);
	c_wr_clear: cover property (wr_evt && evt_flag_q ##1 !evt_flag_q);
	c_flash_wrap: cover property (mode_q[0] == LM_FL3 && tick_q && step_q[0] == 7'h00);
	c_slverr: cover property (rvalid_q && rresp_q == RESP_SLVERR);
	c_run_blink: cover property (mode_q[1] == LM_BLINK ##1 run_led_o);

endmodule // cnl_top

`default_nettype wire

// >>> testbench/cnl_far_side.sv
`timescale 1ns/10ps
`default_nettype none

// ***************************************************************
// stand-in for the switches and the protocol stack
// ***************************************************************
module cnl_far_side (
	input  wire logic  clk_i,
	output logic [3:0] sw_rate_o,
	output logic [3:0] sw_tens_o,
	output logic [3:0] sw_units_o,
	output logic [5:0] stat_o,
	output logic [1:0] nmt_o
);
	// stat_o: 0 lss, 1 warning, 2 bus off, 3 guard, 4 heartbeat, 5 sync
	initial begin
		sw_rate_o = 4'h0;
		sw_tens_o = 4'h0;
		sw_units_o = 4'h0;
		stat_o = 6'h00;
		nmt_o = 2'h0;
	end

	// everything moves just after a rising edge, like the real stack
	task automatic set_all(input logic [3:0] r, t, u, input logic [5:0] s, input logic [1:0] n);
		@(posedge clk_i);
		sw_rate_o <= r;
		sw_tens_o <= t;
		sw_units_o <= u;
		stat_o <= s;
		nmt_o <= n;
	endtask
endmodule // cnl_far_side

`default_nettype wire

// >>> testbench/test_can_node_setting_and_status_leds.sv
`timescale 1ns/10ps
`default_nettype none

module test_can_node_setting_and_status_leds;
	import cnl_pkg::*;

	// ***************************************************************
	// bench signals
	// ***************************************************************
	localparam int TK = 4;
	localparam int ON = int'(ON_TICKS) * TK;
	localparam int LONG = int'(LONG_TICKS) * TK;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, done, err_led, run_led;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [6:0] node_id;
	logic [10:0] rate;
	wire [3:0] sw_r, sw_t, sw_u;
	wire [5:0] stat;
	wire [1:0] nmt;
	int bad_count = 0;
	int tests_run = 0;
	logic [10:0] rates [10] = '{0, 10, 20, 50, 100, 125, 250, 500, 800, 1000};

	always #2 clk = ~clk;

	cnl_far_side u_cnl_far_side (.clk_i(clk), .sw_rate_o(sw_r), .sw_tens_o(sw_t),
		.sw_units_o(sw_u), .stat_o(stat), .nmt_o(nmt));

	cnl_top #(.TICK_CYCLES(TK)) u_cnl_top (.sys_clk_i(clk), .rst_i(rst), .sw_rate_i(sw_r),
		.sw_id_tens_i(sw_t), .sw_id_units_i(sw_u), .lss_busy_i(stat[0]),
		.warn_limit_i(stat[1]), .bus_off_i(stat[2]), .guard_evt_i(stat[3]),
		.hb_evt_i(stat[4]), .sync_err_i(stat[5]), .nmt_state_i(nmt), .node_id_o(node_id),
		.rate_kbps_o(rate), .setting_done_o(done), .err_led_o(err_led), .run_led_o(run_led),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// ***************************************************************
	// shared helpers
	// ***************************************************************
	task automatic report_and_stop();
		$display("mismatches %0d, checks %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask

	// aw and w offered together, each dropped once its own ready is seen
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_p, w_p;
		aw_p = 1;
		w_p = 1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// no cycle count is assumed; only the watchdog ends a hung wait
		while (aw_p || w_p) begin
			@(posedge clk);
			if (aw_p && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_p = 0;
			end
			if (w_p && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_p = 0;
			end
		end
		bready <= 1'b1;
		do begin
			@(posedge clk);
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(posedge clk);
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// a short reset, so the switches are taken again
	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	function automatic logic led_of(input bit sel);
		return sel ? run_led : err_led;
	endfunction

	// length of the current level in cycles, capped at 200 so a stuck led cannot hang
	task automatic run_len(input bit sel, input logic lvl, output int n);
		n = 0;
		while (n < 200 && led_of(sel) === lvl) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	task automatic steady(input bit sel, input logic lvl);
		int n;
		run_len(sel, lvl, n);
		chk("steady led", 200, n);
	endtask

	// skip one partial period, then time a full lit and dark phase
	task automatic check_iso(input bit sel, input int len);
		int h, l;
		run_len(sel, 1'b1, h);
		run_len(sel, 1'b0, l);
		run_len(sel, 1'b1, h);
		run_len(sel, 1'b0, l);
		chk("iso on", len, h);
		chk("iso off", len, l);
	endtask

	// align on the long dark phase, then time k flashes and the pause
	task automatic check_flash(input bit sel, input int k);
		int h, l;
		l = 0;
		for (int i = 0; i < 8 && l < 40; i++) begin
			run_len(sel, 1'b1, h);
			run_len(sel, 1'b0, l);
		end
		for (int i = 0; i < k; i++) begin
			run_len(sel, 1'b1, h);
			run_len(sel, 1'b0, l);
			chk("flash on", ON, h);
			chk("flash off", (i == k - 1) ? LONG : ON, l);
		end
	endtask

	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_switches();
		for (int c = 1; c < 10; c++) begin
			u_cnl_far_side.set_all(4'(c), 4'(c), 4'(9 - c), 6'h00, NMT_INIT);
			do_reset();
			chk("rate", 32'(rates[c]), 32'(rate));
			chk("node id", 32'(c * 10 + 9 - c), 32'(node_id));
		end
		u_cnl_far_side.set_all(4'h2, 4'h1, 4'h4, 6'h00, NMT_INIT);
		repeat (6) @(posedge clk);
		#1;
		chk("held rate", 32'(11'd1000), 32'(rate));
		chk("held id", 32'd90, 32'(node_id));
		chk("done", 32'd1, 32'(done));
	endtask

	task automatic t_stored();
		logic [31:0] d;
		logic [1:0] r;
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h00, NMT_INIT);
		do_reset();
		chk("stored rate", 32'(11'd125), 32'(rate));
		chk("stored id", 32'd1, 32'(node_id));
		axi_read(REG_SET_OFS, d, r);
		chk("source bits", 32'h0000_0003, 32'(d[13:12]));
		axi_write(REG_CFG_OFS, 32'h0000_097f, r);
		chk("cfg write resp", 32'(RESP_OKAY), 32'(r));
		axi_read(REG_CFG_OFS, d, r);
		chk("cfg read resp", 32'(RESP_OKAY), 32'(r));
		chk("stored cfg", 32'h0000_097f, 32'(d[11:0]));
		// the stored copy survives reset and is taken at the next capture
		do_reset();
		chk("stored id 127", 32'd127, 32'(node_id));
		chk("stored rate 9", 32'(11'd1000), 32'(rate));
		axi_write(REG_SET_OFS, 32'h0000_0000, r);
		chk("read-only resp", 32'(RESP_SLVERR), 32'(r));
		axi_read(8'h10, d, r);
		chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
		chk("unmapped data", 32'h0000_0000, d);
	endtask

	task automatic t_run_led();
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h00, NMT_OPER);
		repeat (4) @(posedge clk);
		#1;
		steady(1'b1, 1'b1);
		steady(1'b0, 1'b0);
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h00, NMT_PREOP);
		check_iso(1'b1, ON);
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h00, NMT_STOP);
		check_flash(1'b1, 1);
	endtask

	task automatic t_err_led();
		logic [1:0] r;
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h02, NMT_OPER);
		check_flash(1'b0, 1);
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h0a, NMT_OPER);
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h02, NMT_OPER);
		check_flash(1'b0, 2);
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h10, NMT_OPER);
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h20, NMT_OPER);
		check_flash(1'b0, 3);
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h24, NMT_OPER);
		repeat (4) @(posedge clk);
		#1;
		steady(1'b0, 1'b1);
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h00, NMT_OPER);
		axi_write(REG_EVT_OFS, 32'h0000_0001, r);
		chk("evt write resp", 32'(RESP_OKAY), 32'(r));
		repeat (4) @(posedge clk);
		#1;
		steady(1'b0, 1'b0);
	endtask

	task automatic t_lss();
		int same;
		same = 0;
		u_cnl_far_side.set_all(4'h0, 4'h0, 4'h0, 6'h01, NMT_PREOP);
		check_iso(1'b0, TK);
		for (int i = 0; i < 24; i++) begin
			@(posedge clk);
			#1;
			same += (err_led === run_led) ? 1 : 0;
		end
		chk("flicker overlap", 32'd0, 32'(same));
	endtask

	// ***************************************************************
	// main sequence and watchdog
	// ***************************************************************
	initial begin
		repeat (12) @(posedge clk);
		chk("done in reset", 32'd0, 32'(done));
		rst <= 1'b0;
		t_switches();
		t_stored();
		t_run_led();
		t_err_led();
		t_lss();
		report_and_stop();
	end

	// the whole run needs well under 20000 cycles
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
endmodule // test_can_node_setting_and_status_leds

`default_nettype wire
